// >>> dv/tcp_ext_src.sv
// external count clock source driving one timer count pin
`timescale 1ns/10ps
`default_nettype none

module tcp_ext_src #(
	parameter real HALF_NS = 12.3
) (
	input  wire logic       i_go,
	input  wire logic [7:0] i_pulses,
	output logic            o_pin,
	output logic            o_busy
);
	initial begin
		o_pin = 1'b0;
		o_busy = 1'b0;
	end

	// ==========================================
	// frame of full periods, pin held low outside it
	// half periods above one system clock, rate below clock/2.5
	always @(posedge i_go) begin
		o_busy = 1'b1;
		repeat (i_pulses) begin
			#(HALF_NS) o_pin = 1'b1;
			#(HALF_NS) o_pin = 1'b0;
		end
		// pin stays stable before the select may change
		#(HALF_NS) o_busy = 1'b0;
	end
endmodule

`default_nettype wire

// >>> dv/timer_compare_irq_prescaler_bench.sv
// self-checking bench for the timer compare, flag and prescaler block
`timescale 1ns/10ps
`default_nettype none

module timer_compare_irq_prescaler_bench;
	logic                  clk = 1'b0;
	logic                  rst_n;
	tcp_pkg::tcp_bus_req_t bus;
	logic [7:0]            rdata;
	logic [15:0]           wide, capv, cmp_a, cmp_b;
	logic [3:0]            mode, ack, irq;
	logic [2:0]            cs, cs0;
	logic                  cap_ev, ovf_ev, fa, fb, gie, go;
	logic                  tick, tick0, ma, mb, pin1, pin0, busy1, busy0;
	logic [7:0]            np, en;
	logic [31:0]           seed;
	int                    errors, n_checks, cycles, n16, n0, c;
	localparam logic [7:0] FBIT [6] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h20, 8'h01};
	localparam logic [7:0] ROFS [7] = '{8'h36, 8'h6F, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h43};
	localparam int         DIV [4] = '{8, 64, 256, 1024};

	tcp_timer #(.CNT_WIDTH(16)) dut (
		.i_clock                 (clk),
		.i_rst_n                 (rst_n),
		.i_bus                   (bus),
		.o_rdata                 (rdata),
		.i_wide_counter_value    (wide),
		.i_capture_value         (capv),
		.i_waveform_mode_select  (mode),
		.i_clock_source_select   (cs),
		.i_clock_source_select_t0(cs0),
		.i_external_count_pin    ({pin1, pin0}),
		.i_capture_event         (cap_ev),
		.i_overflow_event        (ovf_ev),
		.i_force_match_a_strobe  (fa),
		.i_force_match_b_strobe  (fb),
		.i_global_irq_enable     (gie),
		.i_vector_ack            (ack),
		.o_timer_tick            (tick),
		.o_timer_tick_t0         (tick0),
		.o_match_a               (ma),
		.o_match_b               (mb),
		.o_irq_req               (irq)
	);
	tcp_ext_src #(.HALF_NS(12.3)) src1 (.i_go(go), .i_pulses(np), .o_pin(pin1), .o_busy(busy1));
	tcp_ext_src #(.HALF_NS(17.1)) src0 (.i_go(go), .i_pulses(np), .o_pin(pin0), .o_busy(busy0));

	always #2.5 clk = ~clk;

	// ==========================================
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ==========================================
	// helpers
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [3:0] irq_of(input logic [7:0] f, input logic [7:0] e);
		return {f[5] & e[5], f[2] & e[2], f[1] & e[1], f[0] & e[0]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cnt(input int n);
		repeat (n) begin
			@(posedge clk);
			n16 += int'(tick);
			n0 += int'(tick0);
		end
		#1;
	endtask
	// one byte access, then an idle cycle so strobes never double up
	task automatic acc(input logic [7:0] a, input logic io, input logic w, input logic [7:0] d);
		bus = '{a, io, w, !w, d};
		cyc(1);
		bus.wr = 1'b0;
		bus.rd = 1'b0;
		cyc(1);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic io, input logic [7:0] e);
		acc(a, io, 1'b0, 8'h00);
		chk(nm, {8'h00, e}, {8'h00, rdata});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		{seed, bus, wide, capv, mode, cs, cs0, ack} = {32'hC1E0, 90'h0};
		{cap_ev, ovf_ev, fa, fb, gie, go, np, rst_n} = 14'h0;
		cyc(20);
		rst_n = 1'b1;
		foreach (ROFS[i]) rdc("reset_value", ROFS[i], 1'b0, 8'h00);
		for (int i = 0; i < 3; i++) begin
			cmp_a = (rnd() & 16'h7FFF) | 16'h0001;
			cmp_b = (rnd() & 16'h7FFF) | 16'h0001;
			acc(8'h89, 1'b0, 1'b1, cmp_a[15:8]);
			acc(8'h88, 1'b0, 1'b1, cmp_a[7:0]);
			acc(8'h8B, 1'b0, 1'b1, cmp_b[15:8]);
			acc(8'h8A, 1'b0, 1'b1, cmp_b[7:0]);
			rdc("cmp_a_lo", 8'h88, 1'b0, cmp_a[7:0]);
			rdc("cmp_b_hi", 8'h8B, 1'b0, cmp_b[15:8]);
			rdc("cmp_b_lo", 8'h8A, 1'b0, cmp_b[7:0]);
			wide = cmp_a;
			cyc(1);
			chk("match_a", 16'h1, 16'(ma));
			wide = cmp_b;
			cyc(1);
			chk("match_b", 16'h1, 16'(mb));
		end
		// high byte aimed at channel a lands in channel b through the shared byte
		acc(8'h89, 1'b0, 1'b1, 8'h5A);
		acc(8'h8A, 1'b0, 1'b1, 8'hC3);
		cmp_b = 16'h5AC3;
		rdc("cmp_b_hi", 8'h8B, 1'b0, 8'h5A);
		rdc("cmp_a_hi", 8'h89, 1'b0, cmp_a[15:8]);
		wide = cmp_a;
		cyc(3);
		chk("stopped_tick", 16'h0, 16'(tick));
		rdc("no_timer_clock", 8'h36, 1'b0, 8'h00);
		{wide, cs, fa, fb} = {16'h0, 3'h1, 2'b11};
		cyc(1);
		chk("forced", 16'h3, {14'h0, ma, mb});
		{fa, fb} = 2'b00;
		rdc("forced_flags", 8'h36, 1'b0, 8'h00);
		for (int k = 0; k < 6; k++) begin
			en = rnd();
			acc(8'h6F, 1'b0, 1'b1, en);
			rdc("enables", 8'h6F, 1'b0, en & tcp_pkg::FLAG_MASK);
			case (k)
				0: wide = 16'hFFFF;
				1: wide = cmp_a;
				2: wide = cmp_b;
				3: cap_ev = 1'b1;
				4: {mode, capv, wide} = {4'hC, 32'h4000_4000};
				default: {mode, ovf_ev} = {4'h1, 1'b1};
			endcase
			cyc(1);
			{wide, cap_ev, ovf_ev, mode} = 22'h0;
			rdc("flags_io", 8'h16, 1'b1, FBIT[k]);
			gie = 1'b1;
			cyc(1);
			chk("irq_on", irq_of(FBIT[k], en), irq);
			gie = 1'b0;
			cyc(1);
			chk("irq_off", 16'h0, 16'(irq));
			if (k[0]) begin
				acc(8'h36, 1'b0, 1'b1, ~FBIT[k]);
				rdc("w0_keeps", 8'h36, 1'b0, FBIT[k]);
				acc(8'h36, 1'b0, 1'b1, FBIT[k]);
			end else begin
				ack = irq_of(FBIT[k], 8'hFF);
				cyc(1);
				ack = 4'h0;
			end
			rdc("flag_clear", 8'h36, 1'b0, 8'h00);
		end
		rdc("io_refused", 8'h4F, 1'b1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			cs = 3'h2 + 3'(i);
			cs0 = i[0] ? cs : 3'h1;
			acc(8'h43, 1'b0, 1'b1, 8'h01);
			c = 0;
			while (tick !== 1'b1 && c <= DIV[i]) begin
				cyc(1);
				c++;
			end
			chk("first_tick", 16'h1, 16'(tick));
			{n16, n0} = 64'h0;
			cnt(2 * DIV[i]);
			chk("tap_ticks", 16'h2, 16'(n16));
			chk("t0_ticks", 16'(i[0] ? 2 : 2 * DIV[i]), 16'(n0));
		end
		cs0 = 3'h2;
		acc(8'h23, 1'b1, 1'b1, 8'h81);
		rdc("held_ctrl", 8'h43, 1'b0, 8'h81);
		{n16, n0} = 64'h0;
		cnt(40);
		chk("held_ticks", 16'h0, 16'(n16 + n0));
		acc(8'h43, 1'b0, 1'b1, 8'h00);
		rdc("released", 8'h23, 1'b1, 8'h00);
		{cs, cs0} = {3'h7, 3'h6};
		np = 8'(3 + rnd() % 5);
		{n16, n0, c} = 96'h0;
		go = 1'b1;
		cnt(1);
		go = 1'b0;
		while ((busy1 | busy0) && c < 400) begin
			cnt(1);
			c++;
		end
		cnt(4);
		chk("ext_rise", 16'(np), 16'(n16));
		chk("ext_fall", 16'(np), 16'(n0));
		np = 8'h01;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		@(posedge pin1);
		c = 0;
		do begin
			cyc(1);
			c++;
		end while (tick !== 1'b1 && c < 5);
		chk("ext_delay", 16'h1, 16'(c <= 2));
		cyc(10);
		tally_and_finish();
	end
endmodule

`default_nettype wire

// >>> pkg/tcp_pkg.sv
// shared constants and carrier types for the timer compare, flag and prescaler block
package tcp_pkg;

	// ==========================================
	// register map (data-space byte offsets)
	localparam logic [7:0] FLAGS_OFS      = 8'h36;
	localparam logic [7:0] PRESC_CTRL_OFS = 8'h43;
	localparam logic [7:0] ENABLES_OFS    = 8'h6F;
	localparam logic [7:0] CMP_A_LO_OFS   = 8'h88;
	localparam logic [7:0] CMP_A_HI_OFS   = 8'h89;
	localparam logic [7:0] CMP_B_LO_OFS   = 8'h8A;
	localparam logic [7:0] CMP_B_HI_OFS   = 8'h8B;
	localparam logic [7:0] IO_SPACE_BIAS  = 8'h20;
	localparam logic [7:0] IO_SPACE_LAST  = 8'h3F;
	localparam logic [7:0] EXT_SPACE_BASE = 8'h60;

	// ==========================================
	// field positions
	localparam int CAPTURE_BIT   = 5;
	localparam int MATCH_B_BIT   = 2;
	localparam int MATCH_A_BIT   = 1;
	localparam int OVERFLOW_BIT  = 0;
	localparam int SYNC_HOLD_BIT = 7;
	localparam int PSR_BIT       = 0;
	localparam logic [7:0] FLAG_MASK = 8'h27;

	// ==========================================
	// reset values
	localparam logic [7:0]  FLAGS_RST   = 8'h00;
	localparam logic [7:0]  ENABLES_RST = 8'h00;
	localparam logic [15:0] CMP_RST     = 16'h0000;
	localparam logic [7:0]  TEMP_RST    = 8'h00;

	// ==========================================
	// clock select codes and prescaler taps
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIRECT = 3'h1;
	localparam logic [2:0] CS_DIV8   = 3'h2;
	localparam logic [2:0] CS_DIV64  = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1K  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_WIDTH = 10;

	// ==========================================
	// waveform modes that matter here
	localparam logic [3:0] WGM_NORMAL   = 4'h0;
	localparam logic [3:0] WGM_CTC_CMP  = 4'h4;
	localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

	// cpu register access, one byte per transfer
	typedef struct packed {
		logic [7:0] addr;
		logic       io_space;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} tcp_bus_req_t;

endpackage

// >>> rtl/tcp_timer.sv
// compare registers, interrupt flags and shared prescaler of the 16-bit timer
// Function
// - both compare values are compared with the running counter continuously.
// - byte writes to compare registers go through one shared high-byte holding register.
// - compare B low byte at base, high byte at base plus one, resets zero.
// - enable bits 5,2,1,0 permit interrupts, gated by global enable and flag.
// - capture flag sets on a capture pin event.
// - with capture value as top, capture flag sets when counter reaches top.
// - match flags set on the timer clock after counter equals compare.
// - forced-compare strobes never set a match flag.
// - flags clear on vector execution or by writing one; zero does nothing.
// - overflow flag sets on counter overflow in normal and clear-on-match modes.
// - flag register answers at data offset 0x36 and I/O offset 0x16.
// - the 8-bit and 16-bit timers share one prescaler, own clock selects.
// - select 1 counts every clock; selects 2 to 5 use taps divide by 8,64,256,1024.
// - prescaler runs freely; first prescaled count comes 1 to N+1 clocks later.
// - prescaler reset restarts the period for every timer on it.
// - external pin sampled each clock; 7 counts rising, 6 falling edges.
// - pin synchroniser is a high-transparent latch then rising-edge registers.
// - counter updates 1.5 to 2.5 clocks after an external pin edge.
// - external edge counting applies no prescaler division.
// - select 0 gives no clock; the timer stops.
// - prescaler reset bit self-clears unless synchronisation hold mode is set.
`timescale 1ns/10ps
`default_nettype none

module tcp_timer #(
	parameter int CNT_WIDTH = 16
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	input  wire tcp_pkg::tcp_bus_req_t  i_bus,
	output logic [7:0]                  o_rdata,
	input  wire logic [CNT_WIDTH-1:0]   i_wide_counter_value,
	input  wire logic [CNT_WIDTH-1:0]   i_capture_value,
	input  wire logic [3:0]             i_waveform_mode_select,
	input  wire logic [2:0]             i_clock_source_select,
	input  wire logic [2:0]             i_clock_source_select_t0,
	input  wire logic [1:0]             i_external_count_pin,
	input  wire logic                   i_capture_event,
	input  wire logic                   i_overflow_event,
	input  wire logic                   i_force_match_a_strobe,
	input  wire logic                   i_force_match_b_strobe,
	input  wire logic                   i_global_irq_enable,
	input  wire logic [3:0]             i_vector_ack,
	output logic                        o_timer_tick,
	output logic                        o_timer_tick_t0,
	output logic                        o_match_a,
	output logic                        o_match_b,
	output logic [3:0]                  o_irq_req
);

	// ==========================================
	// helper functions
	function automatic logic [7:0] eff_addr(input tcp_pkg::tcp_bus_req_t r);
		eff_addr = r.io_space ? 8'(r.addr + tcp_pkg::IO_SPACE_BIAS) : r.addr;
	endfunction

	function automatic logic addr_ok(input tcp_pkg::tcp_bus_req_t r);
		addr_ok = !r.io_space || (r.addr <= tcp_pkg::IO_SPACE_LAST);
	endfunction

	function automatic logic tick_sel(input logic [2:0] cs,
			input logic [3:0] taps, input logic rise, input logic fall);
		unique case (cs)
			tcp_pkg::CS_STOP:     tick_sel = 1'b0;
			tcp_pkg::CS_DIRECT:   tick_sel = 1'b1;
			tcp_pkg::CS_DIV8:     tick_sel = taps[0];
			tcp_pkg::CS_DIV64:    tick_sel = taps[1];
			tcp_pkg::CS_DIV256:   tick_sel = taps[2];
			tcp_pkg::CS_DIV1K:    tick_sel = taps[3];
			tcp_pkg::CS_EXT_FALL: tick_sel = fall;
			tcp_pkg::CS_EXT_RISE: tick_sel = rise;
		endcase
	endfunction

	// ==========================================
	// address decode
	logic [7:0] addr;
	logic       wr;
	logic       rd;
	logic       hit_flags;
	logic       hit_ctrl;
	logic       hit_en;
	logic       hit_a_lo;
	logic       hit_a_hi;
	logic       hit_b_lo;
	logic       hit_b_hi;

	always_comb begin
		addr = eff_addr(i_bus);
		wr   = i_bus.wr && addr_ok(i_bus);
		rd   = i_bus.rd && addr_ok(i_bus);
		hit_flags = addr == tcp_pkg::FLAGS_OFS;
		hit_ctrl  = addr == tcp_pkg::PRESC_CTRL_OFS;
		// extended space is only reached by a data-space access
		hit_en    = !i_bus.io_space && addr == tcp_pkg::ENABLES_OFS;
		hit_a_lo  = !i_bus.io_space && addr == tcp_pkg::CMP_A_LO_OFS;
		hit_a_hi  = !i_bus.io_space && addr == tcp_pkg::CMP_A_HI_OFS;
		hit_b_lo  = !i_bus.io_space && addr == tcp_pkg::CMP_B_LO_OFS;
		hit_b_hi  = !i_bus.io_space && addr == tcp_pkg::CMP_B_HI_OFS;
	end

	// ==========================================
	// shared high-byte holding register and compare values
	logic [7:0]           temp_reg;
	logic [CNT_WIDTH-1:0] cmp_a_reg;
	logic [CNT_WIDTH-1:0] cmp_b_reg;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			temp_reg <= tcp_pkg::TEMP_RST;
		end else if (wr && (hit_a_hi || hit_b_hi)) begin
			temp_reg <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp_a_reg <= tcp_pkg::CMP_RST;
			cmp_b_reg <= tcp_pkg::CMP_RST;
		end else begin
			if (wr && hit_a_lo) begin
				cmp_a_reg <= CNT_WIDTH'({temp_reg, i_bus.wdata});
			end
			if (wr && hit_b_lo) begin
				cmp_b_reg <= CNT_WIDTH'({temp_reg, i_bus.wdata});
			end
		end
	end

	// ==========================================
	// interrupt enables and prescaler control
	logic [7:0] en_reg;
	logic       sync_hold_reg;
	logic       psr_reg;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_reg <= tcp_pkg::ENABLES_RST;
		end else if (wr && hit_en) begin
			en_reg <= i_bus.wdata & tcp_pkg::FLAG_MASK;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_hold_reg <= 1'b0;
			psr_reg       <= 1'b0;
		end else if (wr && hit_ctrl) begin
			sync_hold_reg <= i_bus.wdata[tcp_pkg::SYNC_HOLD_BIT];
			psr_reg       <= i_bus.wdata[tcp_pkg::PSR_BIT];
		end else if (!sync_hold_reg) begin
			psr_reg <= 1'b0;
		end
	end

	// ==========================================
	// free-running shared prescaler
	logic [tcp_pkg::PRESC_WIDTH-1:0] presc_reg;
	logic [3:0]                      taps;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc_reg <= '0;
		end else if (psr_reg) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// each tap fires once per period, on the all-ones count of its bits
	always_comb begin
		taps[0] = &presc_reg[2:0] && !psr_reg;
		taps[1] = &presc_reg[5:0] && !psr_reg;
		taps[2] = &presc_reg[7:0] && !psr_reg;
		taps[3] = &presc_reg[9:0] && !psr_reg;
	end

	// ==========================================
	// external count pin sampling and edge detection
	logic [1:0] pin_latch;
	logic [1:0] pin_sync_reg;
	logic [1:0] pin_prev_reg;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;

	always_latch begin
		if (i_clock) begin
			pin_latch = i_external_count_pin;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_sync_reg <= 2'h0;
			pin_prev_reg <= 2'h0;
		end else begin
			pin_sync_reg <= pin_latch;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	always_comb begin
		pin_rise = pin_sync_reg & ~pin_prev_reg;
		pin_fall = ~pin_sync_reg & pin_prev_reg;
	end

	// ==========================================
	// timer clock selection; both timers tap the same prescaler
	always_comb begin
		// external edges bypass the taps entirely
		o_timer_tick    = tick_sel(i_clock_source_select, taps,
			pin_rise[1], pin_fall[1]);
		o_timer_tick_t0 = tick_sel(i_clock_source_select_t0, taps,
			pin_rise[0], pin_fall[0]);
	end

	// ==========================================
	// compare and flag setting
	logic       eq_a;
	logic       eq_b;
	logic       cap_top;
	logic       ovf_fixed;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [7:0] flags_reg;

	always_comb begin
		eq_a = i_wide_counter_value == cmp_a_reg;
		eq_b = i_wide_counter_value == cmp_b_reg;
		o_match_a = eq_a || i_force_match_a_strobe;
		o_match_b = eq_b || i_force_match_b_strobe;
		cap_top = i_waveform_mode_select[3] && !i_waveform_mode_select[0]
			&& i_waveform_mode_select != 4'h8 + 4'h0 + 4'h0 ? 1'b1
			: i_waveform_mode_select == 4'h8;
		ovf_fixed = i_waveform_mode_select == tcp_pkg::WGM_NORMAL
			|| i_waveform_mode_select == tcp_pkg::WGM_CTC_CMP
			|| i_waveform_mode_select == tcp_pkg::WGM_CTC_CAP;
		flag_set = 8'h00;
		flag_set[tcp_pkg::CAPTURE_BIT] = cap_top
			? o_timer_tick && i_wide_counter_value == i_capture_value
			: i_capture_event;
		// only the counter match sets the flag, never the force strobe
		flag_set[tcp_pkg::MATCH_A_BIT] = o_timer_tick && eq_a;
		flag_set[tcp_pkg::MATCH_B_BIT] = o_timer_tick && eq_b;
		flag_set[tcp_pkg::OVERFLOW_BIT] = ovf_fixed
			? o_timer_tick && i_wide_counter_value == tcp_pkg::COUNT_MAX
			: i_overflow_event;
		flag_clr = {2'h0, i_vector_ack[3], 2'h0, i_vector_ack[2:0]};
		if (wr && hit_flags) begin
			flag_clr = flag_clr | i_bus.wdata;
		end
	end

	// a set in the same cycle as a clear wins
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags_reg <= tcp_pkg::FLAGS_RST;
		end else begin
			flags_reg <= ((flags_reg & ~flag_clr) | flag_set)
				& tcp_pkg::FLAG_MASK;
		end
	end

	// ==========================================
	// interrupt requests: {capture, match b, match a, overflow}
	always_comb begin
		o_irq_req = {flags_reg[5], flags_reg[2:0]} & {en_reg[5], en_reg[2:0]}
			& {4{i_global_irq_enable}};
	end

	// ==========================================
	// read data, one cycle after the read strobe
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (rd) begin
			unique case (1'b1)
				hit_flags: o_rdata <= flags_reg;
				hit_ctrl:  o_rdata <= {sync_hold_reg, 6'h00, psr_reg};
				hit_en:    o_rdata <= en_reg;
				hit_a_lo:  o_rdata <= cmp_a_reg[7:0];
				hit_a_hi:  o_rdata <= cmp_a_reg[15:8];
				hit_b_lo:  o_rdata <= cmp_b_reg[7:0];
				hit_b_hi:  o_rdata <= cmp_b_reg[15:8];
				default:   o_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	property p_match_a_sets;
		o_timer_tick && eq_a |=> flags_reg[tcp_pkg::MATCH_A_BIT];
	endproperty
	a_match_a_sets: assert property (p_match_a_sets)
		else $error("match a flag not set after timer clock match");

	property p_force_no_flag;
		i_force_match_b_strobe && !(o_timer_tick && eq_b)
			&& !flags_reg[tcp_pkg::MATCH_B_BIT]
			|=> !flags_reg[tcp_pkg::MATCH_B_BIT];
	endproperty
	a_force_no_flag: assert property (p_force_no_flag)
		else $error("force strobe set the match b flag");

	property p_w1c;
		wr && hit_flags && i_bus.wdata[tcp_pkg::OVERFLOW_BIT]
			&& !flag_set[tcp_pkg::OVERFLOW_BIT]
			|=> !flags_reg[tcp_pkg::OVERFLOW_BIT];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("writing one did not clear overflow flag");

	property p_commit_b;
		wr && hit_b_lo |=> cmp_b_reg == {$past(temp_reg), $past(i_bus.wdata)};
	endproperty
	a_commit_b: assert property (p_commit_b)
		else $error("compare b did not take holding byte and low byte");

	property p_irq_gate;
		!i_global_irq_enable || en_reg == 8'h00 |-> o_irq_req == 4'h0;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt requested while disabled");

	property p_direct;
		i_clock_source_select == tcp_pkg::CS_DIRECT |-> o_timer_tick;
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct select did not tick every clock");

	property p_stopped;
		i_clock_source_select == tcp_pkg::CS_STOP |-> !o_timer_tick;
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("timer ticked with no clock selected");

	property p_psr_clear;
		wr && hit_ctrl && i_bus.wdata == 8'h01 |=> psr_reg ##1 !psr_reg
			&& presc_reg == 10'h000;
	endproperty
	a_psr_clear: assert property (p_psr_clear)
		else $error("prescaler reset bit did not self-clear");

	property p_ext_rise;
		i_clock_source_select == tcp_pkg::CS_EXT_RISE
			&& !pin_prev_reg[1] ##1 pin_sync_reg[1] && !pin_prev_reg[1]
			|-> o_timer_tick;
	endproperty
	a_ext_rise: assert property (p_ext_rise)
		else $error("rising pin edge gave no timer clock");

endmodule

`default_nettype wire
